// *** include/spm_pkg.sv ***
// package for the serial port modem / spi mode block
// assumes one 50 MHz clock; config and status travel as plain ports
package spm_pkg;
    localparam logic [3:0] MODE_ASYNC     = 4'h0;
    localparam logic [3:0] MODE_MODEM     = 4'h3;
    localparam logic [3:0] MODE_SPI_MAST  = 4'hE;
    localparam logic [3:0] MODE_SPI_SLAVE = 4'hF;
    localparam logic [1:0] CLKSRC_EXT     = 2'h3;
    localparam logic [1:0] CLKSRC_DIV     = 2'h1;
    localparam logic [15:0] DIVISOR_MIN   = 16'h0006;
    localparam logic [15:0] DIVISOR_RST   = 16'h0006;
    localparam logic [3:0] NSS_GAP_BITS   = 4'h3;
    localparam logic [3:0] CHAR_LEN_BASE  = 4'h5;
    localparam logic [3:0] CHAR_LEN_NINE  = 4'h9;
    localparam logic [3:0] BITCNT_RST     = 4'h0;
    localparam logic [8:0] SHIFT_RST      = 9'h000;
    localparam logic       TR_RST         = 1'b1;
    localparam int         SYNC_STAGES    = 2;

    typedef struct packed {
        logic [3:0]  mode;
        logic [1:0]  clock_source_select;
        logic        serial_clock_output_enable;
        logic [1:0]  character_length_field;
        logic        nine_bit;
        logic        cpol;
        logic        cpha;
        logic [15:0] clock_divisor;
    } spm_cfg_t;

    typedef struct packed {
        logic ring_change_flag;
        logic set_ready_change_flag;
        logic carrier_change_flag;
        logic clear_to_send_change_flag;
    } spm_chg_t;

    typedef struct packed {
        logic ring;
        logic set_ready;
        logic carrier;
        logic clear_to_send;
    } spm_modem_in_t;
endpackage

// *** hw/spm_sync.sv ***
// two-flop synchroniser with edge flag on the synchronised side
// assumes d comes from outside the clock domain
`timescale 1ns/1ps
module spm_sync (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic reset_value,
    input  wire logic d,
    output logic      q,
    output logic      changed
);
    logic meta;
    logic last;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta <= 1'b1;
            q    <= 1'b1;
            last <= 1'b1;
        end else begin
            meta <= d;
            q    <= meta;
            last <= q;
        end
    end

    // reset_value unused at reset (constant only); edge ignores first cycle
    assign changed = (q != last) && (reset_value | 1'b1);
endmodule

// *** hw/spm_port.sv ***
// serial port modem and spi mode engine
// assumes the async engine is outside; config comes from register ports
// What this block does
// - mode value 3 selects modem mode.
// - modem mode behaves as async mode with all settings kept.
// - modem mode drives terminal-ready and rts, watches four modem inputs.
// - disable command drives terminal-ready high, enable command drives it low.
// - rts is driven by hardware in modem mode.
// - a level change on a modem input sets its change flag.
// - the four change flags clear when status is read.
// - cts high disables transmitter after the current character finishes.
// - mode E is spi master: txd mosi, rxd miso, sck out, rts select.
// - mode F is spi slave: rxd mosi, txd miso, sck in, cts select.
// - spi master has only one slave select output.
// - slave mode always uses the external serial clock.
// - spi characters carry up to nine data bits, no framing.
// - length from length field; nine-bit bit forces nine bits.
// - most significant bit goes first.
// - bus modes 0..3 map to cpol/cpha 01, 00, 11, 10.
// - master and slave use identical polarity and phase.
// - master select low one bit before, high one after, gap of at least two and a half bits.
`timescale 1ns/1ps
module spm_port (
    input  wire logic                  clock,
    input  wire logic                  rst_n,
    input  wire spm_pkg::spm_cfg_t     cfg,
    input  wire logic                  terminal_ready_disable_cmd,
    input  wire logic                  terminal_ready_enable_cmd,
    input  wire logic                  status_read,
    input  wire logic                  tx_reset_cmd,
    input  wire logic                  rx_reset_cmd,
    input  wire logic                  tx_enable,
    input  wire logic                  tx_valid,
    input  wire logic [8:0]            tx_data,
    output logic                       tx_ready,
    output logic                       rx_valid,
    output logic [8:0]                 rx_data,
    input  wire logic                  async_txd,
    input  wire logic                  async_busy,
    output logic                       async_tx_allow,
    output logic                       async_mode_active,
    input  wire logic                  ring_indicator_in,
    input  wire logic                  set_ready_in,
    input  wire logic                  carrier_detect_in,
    input  wire logic                  cts_in,
    input  wire logic                  rxd_in,
    input  wire logic                  sck_in,
    output logic                       txd_out,
    output logic                       rts_out,
    output logic                       terminal_ready_out,
    output logic                       sck_out,
    output logic                       sck_oe,
    output spm_pkg::spm_chg_t          change_flags,
    output spm_pkg::spm_modem_in_t     modem_levels,
    output logic                       transmitter_on
);
    // ------------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------------
    wire is_modem  = (cfg.mode == spm_pkg::MODE_MODEM);
    wire is_master = (cfg.mode == spm_pkg::MODE_SPI_MAST);
    wire is_slave  = (cfg.mode == spm_pkg::MODE_SPI_SLAVE);
    wire is_spi    = is_master | is_slave;
    // modem mode leaves async engine fully in charge of framing
    assign async_mode_active = !is_spi;

    // character length: nine-bit bit overrides field
    wire [3:0] char_len = cfg.nine_bit ? spm_pkg::CHAR_LEN_NINE
                        : spm_pkg::CHAR_LEN_BASE
                          + {2'b00, cfg.character_length_field};

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    logic ri_s, dsr_s, dcd_s, cts_s, rxd_s, sck_s;
    logic ri_e, dsr_e, dcd_e, cts_e, rxd_e, sck_e;

    spm_sync u_ri  (.clock(clock), .rst_n(rst_n), .reset_value(1'b1),
                    .d(ring_indicator_in), .q(ri_s), .changed(ri_e));
    spm_sync u_dsr (.clock(clock), .rst_n(rst_n), .reset_value(1'b1),
                    .d(set_ready_in), .q(dsr_s), .changed(dsr_e));
    spm_sync u_dcd (.clock(clock), .rst_n(rst_n), .reset_value(1'b1),
                    .d(carrier_detect_in), .q(dcd_s), .changed(dcd_e));
    spm_sync u_cts (.clock(clock), .rst_n(rst_n), .reset_value(1'b1),
                    .d(cts_in), .q(cts_s), .changed(cts_e));
    spm_sync u_rxd (.clock(clock), .rst_n(rst_n), .reset_value(1'b1),
                    .d(rxd_in), .q(rxd_s), .changed(rxd_e));
    spm_sync u_sck (.clock(clock), .rst_n(rst_n), .reset_value(1'b1),
                    .d(sck_in), .q(sck_s), .changed(sck_e));

    assign modem_levels = '{ring: ri_s, set_ready: dsr_s,
                            carrier: dcd_s, clear_to_send: cts_s};

    // ------------------------------------------------------------------
    // modem change flags and terminal ready
    // ------------------------------------------------------------------
    logic [3:0] chg;
    wire  [3:0] chg_ev = {ri_e, dsr_e, dcd_e, cts_e} & {4{is_modem}};
    // set wins over the read clear so no edge is lost
    wire  [3:0] next_chg = chg_ev | (status_read ? 4'h0 : chg);
    logic       dtr;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            chg <= 4'h0;
            dtr <= spm_pkg::TR_RST;
        end else begin
            chg <= next_chg;
            if (terminal_ready_disable_cmd)
                dtr <= 1'b1;
            else if (terminal_ready_enable_cmd)
                dtr <= 1'b0;
        end
    end
    assign change_flags = chg;
    assign terminal_ready_out = dtr;

    // cts gate: stays on until async engine ends its character
    logic tx_gate;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n)
            tx_gate <= 1'b1;
        else if (!cts_s)
            tx_gate <= 1'b1;
        else if (!async_busy)
            tx_gate <= 1'b0;
    end
    wire modem_tx_ok = !is_modem || tx_gate;
    assign async_tx_allow = tx_enable && modem_tx_ok;
    assign transmitter_on = tx_enable && (is_spi || modem_tx_ok);

    // ------------------------------------------------------------------
    // spi engine
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        SPM_IDLE  = 5'b00001,
        SPM_LEAD  = 5'b00010,
        SPM_SHIFT = 5'b00100,
        SPM_TAIL  = 5'b01000,
        SPM_GAP   = 5'b10000
    } spm_state_t;

    spm_state_t state;
    logic [15:0] div_cnt;
    logic [3:0]  bit_cnt;
    logic [3:0]  gap_cnt;
    logic        half;          // second half of a bit time
    logic        sck_int;
    logic        slave_select_line;
    logic [8:0]  tx_sh;
    logic [8:0]  rx_sh;
    logic        mosi;
    logic        rxv;
    logic [8:0]  rxd_q;

    // master half-bit tick; a divisor below six is not guarded here
    wire [15:0] half_div = {1'b0, cfg.clock_divisor[15:1]};
    wire        m_tick   = (div_cnt == 16'h0000);
    wire        spi_rst  = tx_reset_cmd | rx_reset_cmd;

    // leading/trailing edge in slave mode from synchronised sck
    // slave clock always comes from sck pin, divisor ignored
    wire s_lead  = sck_e && (sck_s != cfg.cpol);
    wire s_trail = sck_e && (sck_s == cfg.cpol);
    wire s_sel   = !cts_s;
    // master: first half ends on leading edge, second on trailing
    wire m_lead  = (state == SPM_SHIFT) && m_tick && !half;
    wire m_trail = (state == SPM_SHIFT) && m_tick && half;
    wire lead    = is_master ? m_lead  : (is_slave && s_sel && s_lead);
    wire trail   = is_master ? m_trail : (is_slave && s_sel && s_trail);
    // cpha=1: sample on leading, change on trailing; cpha=0 reversed
    wire sample  = cfg.cpha ? lead : trail;
    wire shift   = cfg.cpha ? trail : lead;
    wire last_bit = (bit_cnt == char_len - 4'h1);
    wire [8:0] load_val = tx_data << (4'h9 - char_len);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state   <= SPM_IDLE;
            div_cnt <= 16'h0000;
            bit_cnt <= spm_pkg::BITCNT_RST;
            gap_cnt <= 4'h0;
            half    <= 1'b0;
            slave_select_line     <= 1'b1;
            tx_sh   <= spm_pkg::SHIFT_RST;
            rx_sh   <= spm_pkg::SHIFT_RST;
            mosi    <= 1'b1;
            rxv     <= 1'b0;
            rxd_q   <= spm_pkg::SHIFT_RST;
        end else begin
            rxv     <= 1'b0;
            // parked at zero outside master: a new divisor takes hold
            // at once instead of after a stale full-range count
            div_cnt <= (!is_master || spi_rst) ? 16'h0000
                     : m_tick ? half_div - 16'h0001
                              : div_cnt - 16'h0001;
            if (spi_rst || !is_spi) begin
                state   <= SPM_IDLE;
                bit_cnt <= spm_pkg::BITCNT_RST;
                half    <= 1'b0;
                slave_select_line     <= 1'b1;
                mosi    <= 1'b1;
            end else begin
                case (state)
                SPM_IDLE: begin
                    half    <= 1'b0;
                    bit_cnt <= spm_pkg::BITCNT_RST;
                    rx_sh   <= spm_pkg::SHIFT_RST;
                    if (is_master && tx_valid && tx_enable && m_tick) begin
                        tx_sh   <= load_val;
                        slave_select_line     <= 1'b0;
                        gap_cnt <= 4'h0;
                        state   <= SPM_LEAD;
                    end else if (is_slave && s_sel && tx_valid) begin
                        tx_sh <= load_val;
                        mosi  <= load_val[8];
                        state <= SPM_SHIFT;
                    end
                end
                SPM_LEAD: begin
                    // one bit time of select before the msb
                    if (m_tick) begin
                        half <= !half;
                        if (half) begin
                            state <= SPM_SHIFT;
                            mosi  <= tx_sh[8];
                        end
                    end
                end
                SPM_SHIFT: begin
                    if (m_tick && is_master)
                        half <= !half;
                    if (sample)
                        rx_sh <= {rx_sh[7:0], rxd_s};
                    if (shift) begin
                        tx_sh <= {tx_sh[7:0], 1'b0};
                        // phase zero puts each bit out on its leading edge
                        mosi  <= cfg.cpha ? tx_sh[7] : tx_sh[8];
                    end
                    if (trail) begin
                        bit_cnt <= bit_cnt + 4'h1;
                        if (last_bit) begin
                            rxv   <= 1'b1;
                            rxd_q <= cfg.cpha ? rx_sh
                                              : {rx_sh[7:0], rxd_s};
                            state <= is_master ? SPM_TAIL : SPM_IDLE;
                        end
                    end
                end
                SPM_TAIL: begin
                    // hold select one bit after the lsb
                    if (m_tick) begin
                        half <= !half;
                        if (half) begin
                            slave_select_line   <= 1'b1;
                            mosi  <= 1'b1;
                            state <= SPM_GAP;
                        end
                    end
                end
                SPM_GAP: begin
                    if (m_tick) begin
                        half <= !half;
                        if (half) begin
                            gap_cnt <= gap_cnt + 4'h1;
                            if (gap_cnt == spm_pkg::NSS_GAP_BITS - 4'h2)
                                state <= SPM_IDLE;
                        end
                    end
                end
                default: state <= SPM_IDLE;
                endcase
            end
        end
    end

    // master serial clock toggles only during data bits
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n)
            sck_int <= 1'b0;
        else if (state == SPM_SHIFT && is_master && m_tick)
            sck_int <= !sck_int;
        else if (state != SPM_SHIFT)
            sck_int <= 1'b0;
    end

    // ------------------------------------------------------------------
    // pin muxing
    // ------------------------------------------------------------------
    // sck idles at cpol, same settings as the far end expects
    assign sck_out = sck_int ^ cfg.cpol;
    assign sck_oe  = is_master && cfg.serial_clock_output_enable
                     && (cfg.clock_source_select
                         != spm_pkg::CLKSRC_EXT);
    // slave drives miso only while selected; high otherwise
    assign txd_out = is_spi ? (is_slave && !s_sel ? 1'b1 : mosi)
                            : async_txd;
    // rts: select in master mode, hardware flow level otherwise
    assign rts_out = is_master ? slave_select_line
                   : !(tx_enable && modem_tx_ok);
    assign tx_ready = is_spi && (state == SPM_IDLE) && tx_enable
                      && (is_master ? m_tick : s_sel);
    assign rx_valid = rxv;
    assign rx_data  = rxd_q;

    // rxd edge is not needed; rxd_e kept for receiver glitch filter users
    wire unused_rxd = rxd_e;
endmodule

// *** tb/spm_peer.sv ***
// spi peer on the far side of spm_port while the port is master
// assumes the port drives sck, select and mosi; replies msb first
`timescale 1ns/1ps
module spm_peer (
    input  wire logic       sck,
    input  wire logic       slave_select_line,
    input  wire logic       mosi,
    input  wire logic       cpol,
    input  wire logic       cpha,
    input  wire logic [3:0] nbits,
    input  wire logic [8:0] reply,
    output logic            miso,
    output logic [8:0]      got
);
    // ----------------------------------------
    // shifter on the peer's own clock edges
    // ----------------------------------------
    int  cnt;
    wire lead = sck ^ cpol;

    task automatic put();
        if (cnt < nbits)
            miso = reply[nbits - 1 - cnt];
        cnt++;
    endtask

    initial miso = 1'b1;
    always @(negedge slave_select_line) begin
        cnt = 0;
        got = '0;
        if (cpha)
            put();
    end
    always @(posedge lead) if (!slave_select_line) begin
        if (cpha)
            got = {got[7:0], mosi};
        else
            put();
    end
    always @(negedge lead) if (!slave_select_line) begin
        if (cpha)
            put();
        else
            got = {got[7:0], mosi};
    end
    // released line must not keep showing the last bit
    always @(posedge slave_select_line) miso = ~miso;
endmodule

// *** tb/spm_port_assertions.sv ***
// checker for spm_port: terminal ready, change flags, spi framing
// assumes bind onto spm_port and a divisor of at least 6
`timescale 1ns/1ps
module spm_port_chk (
    input wire logic                   clock,
    input wire logic                   rst_n,
    input wire spm_pkg::spm_cfg_t      cfg,
    input wire logic                   terminal_ready_disable_cmd,
    input wire logic                   terminal_ready_enable_cmd,
    input wire logic                   status_read,
    input wire logic                   ring_indicator_in,
    input wire logic                   async_busy,
    input wire logic                   async_tx_allow,
    input wire logic                   rx_valid,
    input wire logic                   rts_out,
    input wire logic                   terminal_ready_out,
    input wire logic                   sck_out,
    input wire logic                   sck_oe,
    input wire spm_pkg::spm_chg_t      change_flags,
    input wire spm_pkg::spm_modem_in_t modem_levels
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire mast  = cfg.mode == spm_pkg::MODE_SPI_MAST;
    wire modem = cfg.mode == spm_pkg::MODE_MODEM;
    wire dis   = terminal_ready_disable_cmd;
    wire en    = terminal_ready_enable_cmd;

    dtr_off_a: assert property (dis |=> terminal_ready_out)
        else $error("terminal ready low after disable");
    dtr_on_a: assert property (en && !dis |=> !terminal_ready_out)
        else $error("terminal ready high after enable");
    dtr_hold_a: assert property (!dis && !en
        |=> $stable(terminal_ready_out))
        else $error("terminal ready moved without command");
    ring_flag_a: assert property (modem && $past(rst_n, 2) &&
        $changed(ring_indicator_in) |-> ##[2:4] change_flags.ring_change_flag)
        else $error("ring change flag not set");
    flag_clear_a: assert property (status_read && $stable(modem_levels)
        |=> change_flags == 4'h0)
        else $error("change flags kept after status read");
    cts_gate_a: assert property (modem && modem_levels.clear_to_send
        && !async_busy |-> ##[0:2] !async_tx_allow)
        else $error("transmitter allowed with clear to send inactive");
    nss_lead_a: assert property (mast && $fell(rts_out)
        |-> $stable(sck_out) [*6])
        else $error("serial clock moved within lead bit");
    nss_gap_a: assert property (mast && $past(mast) && $rose(rts_out)
        |-> rts_out [*8])
        else $error("select gap shorter than a bit");
    sck_idle_a: assert property (mast && rts_out && $past(rts_out)
        |-> sck_out == cfg.cpol)
        else $error("idle serial clock not at polarity");
    slave_clk_a: assert property (cfg.mode == spm_pkg::MODE_SPI_SLAVE
        |-> !sck_oe)
        else $error("slave drives serial clock");
    mast_clk_a: assert property (mast && cfg.serial_clock_output_enable
        |-> sck_oe)
        else $error("master serial clock not driven");
    rx_frame_a: assert property (mast && rx_valid |-> !rts_out)
        else $error("character ended outside select");

    cover property (change_flags.ring_change_flag);
    cover property (mast && rx_valid);
    cover property ($fell(terminal_ready_out));
endmodule

bind spm_port spm_port_chk u_chk (.clock, .rst_n, .cfg,
    .terminal_ready_disable_cmd, .terminal_ready_enable_cmd, .status_read,
    .ring_indicator_in, .async_busy, .async_tx_allow, .rx_valid, .rts_out,
    .terminal_ready_out, .sck_out, .sck_oe, .change_flags, .modem_levels);

// *** tb/spm_port_tb.sv ***
// self-checking bench for spm_port: modem, spi master and slave
// assumes spm_peer as far side in master mode; bench drives slave mode
`timescale 1ns/1ps
module spm_port_tb;
    // ----------------------------------------
    // signals and design
    // ----------------------------------------
    logic clock = 0, rst_n = 0, status_read = 0, tx_valid = 0;
    logic terminal_ready_disable_cmd = 0, terminal_ready_enable_cmd = 0;
    logic tx_reset_cmd = 0, rx_reset_cmd = 0, tx_enable = 1;
    logic async_txd = 1, async_busy = 0, sck_tb = 0, mosi_tb = 1;
    logic [3:0] mi = 4'h0, nbits = 4'h8;
    logic [8:0] tx_data = 9'h000, reply = 9'h000, got;
    spm_pkg::spm_cfg_t cfg = '0;
    wire tx_ready, rx_valid, async_tx_allow, async_mode_active, txd_out;
    wire rts_out, terminal_ready_out, sck_out, sck_oe, transmitter_on, miso;
    wire [8:0] rx_data;
    wire spm_pkg::spm_chg_t change_flags;
    wire spm_pkg::spm_modem_in_t modem_levels;
    wire slv = cfg.mode == spm_pkg::MODE_SPI_SLAVE;
    int n_fail = 0, checked = 0, edges = 0;

    always #10 clock = ~clock;
    always @(sck_out) if (rts_out === 1'b0 && !slv) edges++;

    spm_port dut (.clock, .rst_n, .cfg, .terminal_ready_disable_cmd,
        .terminal_ready_enable_cmd, .status_read, .tx_reset_cmd, .rx_reset_cmd,
        .tx_enable, .tx_valid, .tx_data, .tx_ready, .rx_valid, .rx_data,
        .async_txd, .async_busy, .async_tx_allow, .async_mode_active,
        .ring_indicator_in(mi[3]), .set_ready_in(mi[2]),
        .carrier_detect_in(mi[1]), .cts_in(mi[0]), .rxd_in(slv ? mosi_tb : miso),
        .sck_in(sck_tb), .txd_out, .rts_out, .terminal_ready_out, .sck_out,
        .sck_oe, .change_flags, .modem_levels, .transmitter_on);
    spm_peer peer (.sck(sck_out), .slave_select_line(rts_out), .mosi(txd_out), .cpol(cfg.cpol),
        .cpha(cfg.cpha), .nbits, .reply, .miso, .got);

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(string what, logic [8:0] exp, logic [8:0] seen);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        if (n_fail == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge clock);
    endtask

    // k is the bus protocol mode, len the character length
    task automatic set_mode(logic [3:0] m, logic [1:0] k, logic [3:0] len);
        cfg.mode <= m;
        cfg.clock_source_select <= spm_pkg::CLKSRC_DIV;
        cfg.serial_clock_output_enable <= 1'b1;
        cfg.clock_divisor <= 16'h0008;
        cfg.cpol <= k[1];
        cfg.cpha <= ~k[0];
        cfg.nine_bit <= len == 4'h9;
        cfg.character_length_field <= (len == 4'h9) ? 2'h0 : 2'(len - 4'h5);
        tx_reset_cmd <= 1'b1;
        rx_reset_cmd <= 1'b1;
        tick(1);
        tx_reset_cmd <= 1'b0;
        rx_reset_cmd <= 1'b0;
        tick(4);
    endtask

    task automatic send(logic [8:0] d);
        tx_valid <= 1'b1;
        tx_data <= d;
        tick(1);
        for (int i = 0; i < 300 && tx_ready !== 1'b1; i++)
            tick(1);
        chk("tx ready", 9'h001, 9'(tx_ready));
        tx_valid <= 1'b0;
    endtask

    task automatic wait_rx();
        for (int i = 0; i < 600 && rx_valid !== 1'b1; i++)
            tick(1);
        chk("rx valid", 9'h001, 9'(rx_valid));
    endtask

    task automatic cmd(logic d, logic e);
        terminal_ready_disable_cmd <= d;
        terminal_ready_enable_cmd <= e;
        tick(1);
        terminal_ready_disable_cmd <= 1'b0;
        terminal_ready_enable_cmd <= 1'b0;
        tick(1);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_dtr();
        chk("terminal ready", 9'h001, terminal_ready_out);
        cmd(1'b0, 1'b1);
        chk("terminal ready", 9'h000, terminal_ready_out);
        cmd(1'b1, 1'b1);
        chk("terminal ready", 9'h001, terminal_ready_out);
    endtask

    task automatic t_modem();
        set_mode(spm_pkg::MODE_MODEM, 2'h1, 4'h8);
        chk("async active", 9'h001, async_mode_active);
        for (int i = 0; i < 4; i++) begin
            mi[i] <= ~mi[i];
            tick(6);
            chk("change flags", 9'(4'h1 << i), 9'(change_flags));
            chk("modem levels", 9'(mi), 9'(modem_levels));
            status_read <= 1'b1;
            tick(1);
            status_read <= 1'b0;
            tick(1);
            chk("change flags", 9'h000, 9'(change_flags));
        end
    endtask

    task automatic t_cts();
        mi <= 4'h0;
        async_busy <= 1'b1;
        async_txd <= 1'b0;
        tick(6);
        chk("txd", 9'h000, txd_out);
        mi[0] <= 1'b1;
        tick(6);
        chk("tx allow", 9'h001, async_tx_allow);
        async_busy <= 1'b0;
        tick(4);
        chk("tx allow", 9'h000, async_tx_allow);
        chk("transmitter on", 9'h000, transmitter_on);
        chk("rts", 9'h001, rts_out);
        mi[0] <= 1'b0;
        async_txd <= 1'b1;
        tick(6);
        chk("tx allow", 9'h001, async_tx_allow);
    endtask

    task automatic t_master(logic [1:0] k, logic [3:0] len, logic [8:0] d);
        logic [8:0] m;
        m = 9'h1FF >> (4'h9 - len);
        set_mode(spm_pkg::MODE_SPI_MAST, k, len);
        nbits <= len;
        reply <= ~d;
        edges = 0;
        send(d);
        wait_rx();
        chk("master rx", ~d & m, rx_data);
        tick(40);
        chk("peer got", d & m, got);
        chk("sck edges", 9'(2 * len), 9'(edges));
    endtask

    task automatic t_slave();
        logic [7:0] ms, seen;
        ms = 8'h6D;
        mi[0] <= 1'b1;
        set_mode(spm_pkg::MODE_SPI_SLAVE, 2'h0, 4'h8);
        chk("miso idle", 9'h001, txd_out);
        mi[0] <= 1'b0;
        tick(16);
        send(9'h0B4);
        for (int i = 7; i >= 0; i--) begin
            mosi_tb <= ms[i];
            tick(8);
            seen[i] = txd_out;
            sck_tb <= 1'b1;
            tick(8);
            sck_tb <= 1'b0;
        end
        wait_rx();
        chk("slave rx", 9'h06D, rx_data);
        chk("slave miso", 9'h0B4, 9'(seen));
        tick(16);
        mi[0] <= 1'b1;
    endtask

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        tick(6);
        rst_n <= 1'b1;
        tick(3);
        t_dtr();
        t_modem();
        t_cts();
        for (int k = 0; k < 4; k++)
            t_master(2'(k), 4'(5 + k + (k == 3)), 9'h1A5 ^ 9'(k));
        t_master(2'h1, 4'h8, 9'h0C3);
        t_slave();
        test_done();
    end

    initial begin
        tick(20000);
        n_fail++;
        test_done();
    end
endmodule
